// ===== shared/fifo_x9_pkg.sv
// ============================================================
// Shared constants and carrier types for the 9-bit FIFO.
// ============================================================
package fifo_x9_pkg;

  // ============================================================
  // Storage geometry.
  // ============================================================
  localparam int DATA_W = 9;                 // Width of one stored word.
  localparam int PTR_W = 6;                  // Pointer width for 64 words.
  localparam int CNT_W = 7;                  // Fill count reaches 64.
  localparam logic [6:0] DEPTH = 7'h40;      // Words of storage.
  localparam logic [5:0] AE_OFF_RST = 6'h07; // Almost-empty offset after reset.
  localparam logic [5:0] AF_OFF_RST = 6'h07; // Almost-full offset after reset.

  // ============================================================
  // Register map, byte addresses on the AXI4-Lite slave.
  // ============================================================
  localparam int ADDR_W = 8;                      // Address bits decoded.
  localparam logic [7:0] REG_AE_OFFSET = 8'h00;   // Almost-empty offset, RW.
  localparam logic [7:0] REG_AF_OFFSET = 8'h04;   // Almost-full offset, RW.
  localparam logic [7:0] REG_FIFO_STATE = 8'h08;  // Fill count and flags, RO.
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0C;  // Sticky events, RO.
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h10;   // Write one to clear, WO.
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h14;  // Event enables, RW.

  // Field positions inside the fifo state register.
  localparam int ST_EMPTY_N = 8;   // Empty flag, low when empty.
  localparam int ST_FULL_N = 9;    // Full flag, low when full.
  localparam int ST_AEMPTY_N = 10; // Almost-empty flag.
  localparam int ST_AFULL_N = 11;  // Almost-full flag.
  localparam int ST_MODE_EN2 = 12; // One when the dual pin is a second enable.

  // Event bits shared by status, clear and enable.
  localparam int EV_OVERFLOW = 0;  // Write refused while full.
  localparam int EV_UNDERFLOW = 1; // Read refused while empty.
  localparam int EV_AFULL = 2;     // Almost-full flag asserted.
  localparam int EV_AEMPTY = 3;    // Almost-empty flag asserted.
  localparam int EV_W = 4;         // Number of events.

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;   // Mapped access, except a read of the clear register.
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped access.

  // Register index decode result.
  typedef enum logic [2:0] {
    SEL_AE, SEL_AF, SEL_STATE, SEL_IST, SEL_ICLR, SEL_IEN, SEL_NONE
  } reg_sel_t;

  // Master-to-slave AXI4-Lite signals.
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  // Slave-to-master AXI4-Lite signals.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage

// ===== design/fifo_x9.sv
`timescale 1ns/10ps
// Overview of operation
// - Reset works while the clock keeps running.
// - After reset data reads zero when enabled.
// - Dual pin high at reset: second enable.
// - Dual pin low at reset: offset load.
// - First word follows empty flag release.
// - First read latency bounded after empty write.
// - Almost-empty low below n words stored.
// - Almost-full low near full by offset.
// - Almost-full threshold is depth minus m.
// - Almost-full flag updates on the write edge.
// - Almost-empty flag updates on the read edge.
// - Full flag releases on the write edge.
// - Empty flag releases on the read edge.
module fifo_x9 (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [fifo_x9_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en_primary_n,
  input wire logic i_wr_en2_or_load,
  input wire logic i_rd_en_primary_n,
  input wire logic i_rd_en_secondary_n,
  input wire logic i_out_en_n,
  input wire fifo_x9_pkg::axil_req_t i_axi,
  output logic [fifo_x9_pkg::DATA_W-1:0] o_rd_data,
  output logic o_rd_data_oe,
  output logic o_empty_flag_n,
  output logic o_full_flag_n,
  output logic o_almost_empty_flag_n,
  output logic o_almost_full_flag_n,
  output logic o_irq,
  output fifo_x9_pkg::axil_rsp_t o_axi
);
  import fifo_x9_pkg::*;

  // ============================================================
  // State of the block.
  // ============================================================
  typedef struct packed {
    logic [CNT_W-1:0] cnt;     // Words held.
    logic [PTR_W-1:0] wptr;    // Next slot to fill.
    logic [PTR_W-1:0] rptr;    // Next slot to drain.
    logic mode_en2;            // Dual pin acts as second enable.
    logic mode_pend;           // Mode not yet sampled since reset.
    logic load_af;             // Next load goes to the almost-full offset.
    logic [5:0] ae_off;        // Almost-empty offset n.
    logic [5:0] af_off;        // Almost-full offset m.
    logic [DATA_W-1:0] rdata;  // Read data output register.
    logic oe;                  // Read data drive enable.
    logic empty_n;             // Empty flag.
    logic full_n;              // Full flag.
    logic aempty_n;            // Almost-empty flag.
    logic afull_n;             // Almost-full flag.
    logic [EV_W-1:0] ist;      // Sticky events.
    logic [EV_W-1:0] ien;      // Event enables.
    logic irq;                 // Interrupt output register.
    logic aw_held;             // Write address captured.
    logic [ADDR_W-1:0] awaddr; // Captured write address.
    logic w_held;              // Write data captured.
    logic [31:0] wdata;        // Captured write data.
    logic [3:0] wstrb;         // Captured byte strobes.
    axil_rsp_t rsp;            // Registered bus outputs.
  } state_t;

  state_t st_r;   // Current state.
  state_t st_nxt; // Next state.
  logic [DATA_W-1:0] mem [0:63]; // Word storage.
  logic wr_try;   // Writer asks to store a word.
  logic load_try; // Writer asks to load an offset.
  logic rd_try;   // Reader asks for a word.
  logic wr_ok;    // Write taken.
  logic rd_ok;    // Read taken.

  // Maps a byte address onto a register selector.
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    case (addr)
      REG_AE_OFFSET: decode = SEL_AE;
      REG_AF_OFFSET: decode = SEL_AF;
      REG_FIFO_STATE: decode = SEL_STATE;
      REG_IRQ_STATUS: decode = SEL_IST;
      REG_IRQ_CLEAR: decode = SEL_ICLR;
      REG_IRQ_ENABLE: decode = SEL_IEN;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // ============================================================
  // Pin qualification.
  // ============================================================
  // Decodes the writer and reader enables against the latched mode.
  always_comb begin
    if (st_r.mode_en2) begin
      wr_try = !i_wr_en_primary_n && i_wr_en2_or_load;
      load_try = 1'b0;
    end else begin
      wr_try = !i_wr_en_primary_n && i_wr_en2_or_load;
      load_try = !i_wr_en_primary_n && !i_wr_en2_or_load && !st_r.mode_pend;
    end
    rd_try = !i_rd_en_primary_n && !i_rd_en_secondary_n;
    // Reads only see the registered empty flag, so a fresh word waits a cycle.
    wr_ok = wr_try && st_r.full_n;
    rd_ok = rd_try && st_r.empty_n;
  end

  // ============================================================
  // Next-state logic.
  // ============================================================
  // Computes pointers, flags, offsets, events and the bus slave.
  always_comb begin
    logic [CNT_W-1:0] cnt_n;
    logic [EV_W-1:0] ev;
    logic [31:0] rd_word;
    logic do_write;
    st_nxt = st_r;
    cnt_n = st_r.cnt;
    ev = '0;
    rd_word = '0;
    do_write = 1'b0;

    // The dual pin is sampled at the first edge after reset is released.
    if (st_r.mode_pend) begin
      st_nxt.mode_pend = 1'b0;
      st_nxt.mode_en2 = i_wr_en2_or_load;
    end
    // Pointer and count movement.
    if (wr_ok) begin
      st_nxt.wptr = st_r.wptr + 6'h01;
    end
    if (rd_ok) begin
      st_nxt.rptr = st_r.rptr + 6'h01;
      st_nxt.rdata = mem[st_r.rptr];
    end
    if (wr_ok && !rd_ok) begin
      cnt_n = st_r.cnt + 7'h01;
    end else if (rd_ok && !wr_ok) begin
      cnt_n = st_r.cnt - 7'h01;
    end
    st_nxt.cnt = cnt_n;
    st_nxt.oe = !i_out_en_n;
    // Offset load over the pins alternates almost-empty then almost-full.
    if (load_try) begin
      if (st_r.load_af) begin
        st_nxt.af_off = i_wr_data[5:0];
      end else begin
        st_nxt.ae_off = i_wr_data[5:0];
      end
      st_nxt.load_af = !st_r.load_af;
    end
    // ----- Bus write path: address and data are taken in either order.
    if (i_axi.awvalid && st_r.rsp.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = i_axi.awaddr;
      st_nxt.rsp.awready = 1'b0;
    end
    if (i_axi.wvalid && st_r.rsp.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = i_axi.wdata;
      st_nxt.wstrb = i_axi.wstrb;
      st_nxt.rsp.wready = 1'b0;
    end
    if (st_r.aw_held && st_r.w_held && !st_r.rsp.bvalid) begin
      do_write = st_r.wstrb[0];
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      st_nxt.rsp.bresp = (decode(st_r.awaddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (st_r.rsp.bvalid && i_axi.bready) begin
      st_nxt.rsp.bvalid = 1'b0;
      st_nxt.rsp.awready = 1'b1;
      st_nxt.rsp.wready = 1'b1;
    end
    // A pin load in the same cycle wins over a bus write to the same offset.
    if (do_write) begin
      case (decode(st_r.awaddr))
        SEL_AE: begin
          if (!(load_try && !st_r.load_af)) begin
            st_nxt.ae_off = st_r.wdata[5:0];
          end
        end
        SEL_AF: begin
          if (!(load_try && st_r.load_af)) begin
            st_nxt.af_off = st_r.wdata[5:0];
          end
        end
        SEL_ICLR: begin
          st_nxt.ist = st_r.ist & ~st_r.wdata[EV_W-1:0];
        end
        SEL_IEN: begin
          st_nxt.ien = st_r.wdata[EV_W-1:0];
        end
        default: begin end
      endcase
    end
    // Flags follow the new count in the same edge, as one clock drives both ports.
    st_nxt.empty_n = (cnt_n != 7'h00);
    st_nxt.full_n = (cnt_n != DEPTH);
    st_nxt.aempty_n = !(cnt_n < {1'b0, st_nxt.ae_off});
    st_nxt.afull_n = !(cnt_n >= (DEPTH - {1'b0, st_nxt.af_off}));
    // Events; a set in the clearing cycle survives the clear.
    ev[EV_OVERFLOW] = wr_try && !st_r.full_n;
    ev[EV_UNDERFLOW] = rd_try && !st_r.empty_n;
    ev[EV_AFULL] = st_r.afull_n && !st_nxt.afull_n;
    ev[EV_AEMPTY] = st_r.aempty_n && !st_nxt.aempty_n;
    st_nxt.ist = st_nxt.ist | ev;
    st_nxt.irq = |(st_nxt.ist & st_nxt.ien);
    // ----- Bus read path: answer one cycle after the address is taken.
    case (decode(i_axi.araddr))
      SEL_AE: rd_word = {26'h0, st_r.ae_off};
      SEL_AF: rd_word = {26'h0, st_r.af_off};
      SEL_STATE: begin
        rd_word[CNT_W-1:0] = st_r.cnt;
        rd_word[ST_EMPTY_N] = st_r.empty_n;
        rd_word[ST_FULL_N] = st_r.full_n;
        rd_word[ST_AEMPTY_N] = st_r.aempty_n;
        rd_word[ST_AFULL_N] = st_r.afull_n;
        rd_word[ST_MODE_EN2] = st_r.mode_en2;
      end
      SEL_IST: rd_word = {28'h0, st_r.ist};
      SEL_IEN: rd_word = {28'h0, st_r.ien};
      default: rd_word = '0;
    endcase
    if (i_axi.arvalid && st_r.rsp.arready) begin
      st_nxt.rsp.arready = 1'b0;
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rdata = rd_word;
      st_nxt.rsp.rresp = (decode(i_axi.araddr) == SEL_NONE || decode(i_axi.araddr) == SEL_ICLR) ?
                         RESP_SLVERR : RESP_OKAY;
    end
    if (st_r.rsp.rvalid && i_axi.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
      st_nxt.rsp.arready = 1'b1;
    end
  end

  // ============================================================
  // State register.
  // ============================================================
  // Asynchronous reset loads constants only; the clock may keep running.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.mode_en2 <= 1'b1;
      st_r.mode_pend <= 1'b1;
      st_r.ae_off <= AE_OFF_RST;
      st_r.af_off <= AF_OFF_RST;
      st_r.full_n <= 1'b1;
      st_r.afull_n <= 1'b1;
      st_r.rsp.awready <= 1'b1;
      st_r.rsp.wready <= 1'b1;
      st_r.rsp.arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Storage writes need no reset.
  always_ff @(posedge i_ref_clk) begin
    if (wr_ok) begin
      mem[st_r.wptr] <= i_wr_data;
    end
  end

  // Outputs come straight from state flip-flops.
  assign o_rd_data = st_r.rdata;
  assign o_rd_data_oe = st_r.oe;
  assign o_empty_flag_n = st_r.empty_n;
  assign o_full_flag_n = st_r.full_n;
  assign o_almost_empty_flag_n = st_r.aempty_n;
  assign o_almost_full_flag_n = st_r.afull_n;
  assign o_irq = st_r.irq;
  assign o_axi = st_r.rsp;

  // ============================================================
  // Checks.
  // ============================================================
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_write_into_empty;
    wr_ok && (st_r.cnt == 7'h00) && !rd_try;
  endsequence
  sequence s_word_visible;
    o_empty_flag_n ##1 1'b1;
  endsequence

  property p_reset_levels;
    $rose(i_rst_n) |-> st_r.cnt == 7'h00 && !o_empty_flag_n && !o_almost_empty_flag_n && o_full_flag_n;
  endproperty
  a_reset_levels: assert property (p_reset_levels) else $error("flag levels wrong after reset");
  property p_zero_data;
    $rose(i_rst_n) |-> o_rd_data == 9'h000;
  endproperty
  a_zero_data: assert property (p_zero_data) else $error("read data not zero after reset");
  // The drive enable mirrors the pin one edge late, both ways, once reset has been gone an edge.
  property p_oe_follow;
    $past(i_rst_n) |-> o_rd_data_oe == !$past(i_out_en_n);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("data drive does not follow enable");
  property p_mode_latch;
    $fell(st_r.mode_pend) |-> st_r.mode_en2 == $past(i_wr_en2_or_load);
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("dual pin mode not latched");
  property p_load_no_store;
    load_try && !rd_try |=> $stable(st_r.wptr) && $stable(st_r.cnt);
  endproperty
  a_load_no_store: assert property (p_load_no_store) else $error("load stored a word");
  property p_first_word;
    s_write_into_empty |=> s_word_visible;
  endproperty
  a_first_word: assert property (p_first_word) else $error("empty flag late after write");
  property p_read_data;
    rd_ok |=> o_rd_data == $past(mem[st_r.rptr]) && st_r.rptr == $past(st_r.rptr) + 6'h01;
  endproperty
  a_read_data: assert property (p_read_data) else $error("read word or pointer wrong");
  property p_full_refuse;
    !o_full_flag_n && wr_try |=> $stable(st_r.wptr);
  endproperty
  a_full_refuse: assert property (p_full_refuse) else $error("write taken while full");
  property p_empty_refuse;
    !o_empty_flag_n && rd_try |=> $stable(st_r.rptr) && $stable(o_rd_data);
  endproperty
  a_empty_refuse: assert property (p_empty_refuse) else $error("read taken while empty");
  property p_almost_empty;
    o_almost_empty_flag_n == !(st_r.cnt < {1'b0, st_r.ae_off});
  endproperty
  a_almost_empty: assert property (p_almost_empty) else $error("almost-empty flag wrong");
  property p_almost_full;
    (st_r.cnt >= DEPTH - {1'b0, st_r.af_off}) |-> !o_almost_full_flag_n;
  endproperty
  a_almost_full: assert property (p_almost_full) else $error("almost-full flag wrong");
  property p_empty_track;
    $changed(st_r.cnt) |-> o_empty_flag_n == (st_r.cnt != 7'h00) && o_full_flag_n == (st_r.cnt != DEPTH);
  endproperty
  a_empty_track: assert property (p_empty_track) else $error("full or empty flag lags count");

endmodule

// ===== sim/fifo_port_model.sv
`timescale 1ns/10ps
// ============================================================
// Writer and reader logic that face the FIFO pins.
// ============================================================
module fifo_port_model (
  input wire logic i_ref_clk,
  input wire logic i_full_flag_n,
  input wire logic i_wr_req,
  input wire logic i_rd_req,
  input wire logic i_load_req,
  input wire logic [5:0] i_load_val,
  input wire logic i_mode_en2,
  output logic [8:0] o_wr_data,
  output logic o_wr_en_primary_n,
  output logic o_wr_en2_or_load,
  output logic o_rd_en_primary_n,
  output logic o_rd_en_secondary_n
);
  logic [8:0] seq_r = 9'h000; // Count of words the FIFO has taken.
  logic [8:0] word; // Word offered next.
  assign word = seq_r ^ 9'h155;
  // Idle data is the inverse of the word, so stale data never looks valid.
  assign o_wr_data = i_load_req ? {3'h0, i_load_val} : (i_wr_req ? word : ~word);
  assign o_wr_en_primary_n = !(i_wr_req || i_load_req);
  // The dual pin rests at the mode level, so it is held through reset.
  assign o_wr_en2_or_load = i_load_req ? 1'b0 : (i_wr_req | i_mode_en2);
  assign o_rd_en_primary_n = !i_rd_req;
  assign o_rd_en_secondary_n = !i_rd_req;
  // Step to the next word only when the FIFO could take this one.
  always @(posedge i_ref_clk) begin
    if (i_wr_req && !i_load_req && i_full_flag_n) begin
      seq_r <= seq_r + 9'h001;
    end
  end
endmodule

// ===== sim/tb.sv
`timescale 1ns/10ps
// ============================================================
// Self-checking bench for the 9-bit FIFO.
// ============================================================
module tb;
  import fifo_x9_pkg::*;
  logic ref_clk = 1'b0; // System clock.
  logic rst_n = 1'b0; // Reset, active low.
  logic wr_req = 1'b0, rd_req = 1'b0, ld_req = 1'b0; // Port requests.
  logic [5:0] ld_val = 6'h00; // Offset load value.
  logic mode = 1'b1; // Dual pin level at rest.
  logic out_en_n = 1'b0; // Output enable, active low.
  axil_req_t ax = '0; // Bus master signals.
  axil_rsp_t rs; // Bus slave signals.
  logic [8:0] wd, rd; // Write and read data.
  logic wen, wen2, rd_en_primary_n, rd_en_secondary_n, oe, e_n, f_n, ae_n, af_n, irq; // Pins.
  logic [31:0] v; // Bus read data.
  logic [1:0] rp, bp; // Bus read and write responses.
  int n_fail = 0, n_tests = 0, cyc = 0, cur = 0;
  typedef struct {int fill; logic [3:0] flags;} row_t; // Fill and {e,ae,af,f}.
  row_t rows[6] = '{'{1, 4'hB}, '{6, 4'hB}, '{7, 4'hF}, '{56, 4'hF}, '{57, 4'hD}, '{64, 4'hC}};

  always #5 ref_clk = ~ref_clk;

  fifo_port_model u_port (.i_ref_clk(ref_clk), .i_full_flag_n(f_n), .i_wr_req(wr_req),
    .i_rd_req(rd_req), .i_load_req(ld_req), .i_load_val(ld_val), .i_mode_en2(mode),
    .o_wr_data(wd), .o_wr_en_primary_n(wen), .o_wr_en2_or_load(wen2),
    .o_rd_en_primary_n(rd_en_primary_n), .o_rd_en_secondary_n(rd_en_secondary_n));

  fifo_x9 DUT (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_wr_data(wd), .i_wr_en_primary_n(wen),
    .i_wr_en2_or_load(wen2), .i_rd_en_primary_n(rd_en_primary_n), .i_rd_en_secondary_n(rd_en_secondary_n),
    .i_out_en_n(out_en_n), .i_axi(ax), .o_rd_data(rd), .o_rd_data_oe(oe),
    .o_empty_flag_n(e_n), .o_full_flag_n(f_n), .o_almost_empty_flag_n(ae_n),
    .o_almost_full_flag_n(af_n), .o_irq(irq), .o_axi(rs));

  // ============================================================
  // Helpers.
  // ============================================================
  // Expected word number i from the writer.
  function automatic logic [8:0] word(input int i);
    return 9'(i) ^ 9'h155;
  endfunction

  // Compare and report one value.
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Bus write: address and data offered together, each released when taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge ref_clk);
    ax.awvalid <= 1'b1;
    ax.awaddr <= a;
    ax.wvalid <= 1'b1;
    ax.wdata <= d;
    ax.wstrb <= 4'hF;
    ax.bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (aw && w && rs.bvalid) break;
      aw = aw | rs.awready;
      w = w | rs.wready;
      ax.awvalid <= !aw;
      ax.wvalid <= !w;
    end
    bp = rs.bresp;
    ax.bready <= 1'b0;
  endtask

  // Bus read: data and response taken at the rvalid edge.
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] re);
    logic t;
    t = 1'b0;
    @(posedge ref_clk);
    ax.arvalid <= 1'b1;
    ax.araddr <= a;
    ax.rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (t && rs.rvalid) break;
      t = t | rs.arready;
      ax.arvalid <= !t;
    end
    d = rs.rdata;
    re = rs.rresp;
    ax.rready <= 1'b0;
  endtask

  // Write k words back to back; k is at least one.
  task automatic push(input int k);
    @(posedge ref_clk);
    wr_req <= 1'b1;
    repeat (k) @(posedge ref_clk);
    wr_req <= 1'b0;
    #1;
  endtask

  // Reset with the clock running and the dual pin at level m.
  task automatic do_reset(input logic m);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    mode <= m;
    repeat (20) @(posedge ref_clk);
    #1 chk("reset flags", 4'h3, {e_n, ae_n, af_n, f_n});
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Hang guard: well above the few hundred cycles the run needs.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      conclude;
    end
  end

  // ============================================================
  // Main sequence.
  // ============================================================
  initial begin
    do_reset(1'b1);
    chk("zero out", 10'h200, {oe, rd});
    @(posedge ref_clk);
    out_en_n <= 1'b1;
    @(posedge ref_clk);
    #1 chk("oe off", 1'b0, oe);
    axr(REG_FIFO_STATE, v, rp);
    chk("mode en2", 1'b1, v[ST_MODE_EN2]);
    // A low dual pin in second-enable mode neither writes nor loads.
    @(posedge ref_clk);
    ld_req <= 1'b1;
    ld_val <= 6'h02;
    @(posedge ref_clk);
    ld_req <= 1'b0;
    axr(REG_FIFO_STATE, v, rp);
    chk("no write", 7'h00, v[6:0]);
    axr(REG_AE_OFFSET, v, rp);
    chk("no load", 32'h7, v);
    axw(REG_IRQ_ENABLE, 32'h1);
    // Fill in steps and compare the flags at each row.
    foreach (rows[i]) begin
      push(rows[i].fill - cur);
      cur = rows[i].fill;
      chk("flags", rows[i].flags, {e_n, ae_n, af_n, f_n});
    end
    // Write while full is refused and raises the overflow event.
    push(1);
    axr(REG_FIFO_STATE, v, rp);
    chk("full count", 7'h40, v[6:0]);
    chk("irq ovf", 1'b1, irq);
    axr(REG_IRQ_STATUS, v, rp);
    chk("status", 32'h5, v);
    axw(REG_IRQ_CLEAR, 32'h1);
    axr(REG_IRQ_STATUS, v, rp);
    chk("cleared", 32'h4, v);
    chk("irq low", 1'b0, irq);
    // Drain back to back and check order.
    @(posedge ref_clk);
    rd_req <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge ref_clk);
      if (i == 63) rd_req <= 1'b0;
      #1 chk("read word", word(i), rd);
    end
    chk("empty flags", 4'h3, {e_n, ae_n, af_n, f_n});
    // Read while empty leaves the data alone.
    @(posedge ref_clk);
    rd_req <= 1'b1;
    @(posedge ref_clk);
    rd_req <= 1'b0;
    #1 chk("underflow", word(63), rd);
    // Write to empty, read at the very next edge.
    @(posedge ref_clk);
    wr_req <= 1'b1;
    @(posedge ref_clk);
    wr_req <= 1'b0;
    rd_req <= 1'b1;
    #1 chk("empty off", 1'b1, e_n);
    chk("not early", word(63), rd);
    @(posedge ref_clk);
    rd_req <= 1'b0;
    #1 chk("first word", word(64), rd);
    axr(8'h20, v, rp);
    chk("unmapped", {30'h0, RESP_SLVERR}, {v[29:0], rp});
    axr(REG_IRQ_STATUS, v, rp);
    chk("status 2", 32'hE, v);
    axw(REG_IRQ_ENABLE, 32'h2);
    chk("irq udf", 1'b1, irq);
    axw(REG_IRQ_CLEAR, 32'hF);
    chk("irq off", 1'b0, irq);
    // Second reset in load mode, then two back-to-back offset loads.
    do_reset(1'b0);
    axr(REG_FIFO_STATE, v, rp);
    chk("mode load", 1'b0, v[ST_MODE_EN2]);
    @(posedge ref_clk);
    ld_req <= 1'b1;
    ld_val <= 6'h03;
    @(posedge ref_clk);
    ld_val <= 6'h05;
    @(posedge ref_clk);
    ld_req <= 1'b0;
    axr(REG_AE_OFFSET, v, rp);
    chk("ae off", 32'h3, v);
    axr(REG_AF_OFFSET, v, rp);
    chk("af off", 32'h5, v);
    push(2);
    chk("ae at 2", 1'b0, ae_n);
    push(1);
    chk("ae at 3", 1'b1, ae_n);
    push(55);
    chk("af at 58", 1'b1, af_n);
    push(1);
    chk("af at 59", 1'b0, af_n);
    // Offsets written over the bus move the flags at once.
    axw(REG_AE_OFFSET, 32'h3C);
    chk("bresp ok", RESP_OKAY, bp);
    chk("ae by bus", 1'b0, ae_n);
    axw(REG_AF_OFFSET, 32'h0);
    chk("af m zero", 1'b1, af_n);
    axr(REG_IRQ_STATUS, v, rp);
    chk("status 3", 32'hC, v);
    // Unmapped write and a read of the clear register are refused.
    axw(8'h20, 32'h1);
    chk("bresp err", RESP_SLVERR, bp);
    axr(REG_IRQ_CLEAR, v, rp);
    chk("clr data", 32'h0, v);
    chk("clr resp", RESP_SLVERR, rp);
    conclude;
  end
endmodule
